// file: hw/artmr_pkg.sv
// package: register map, field positions, reset values and divider counts of the timer
package artmr_pkg;

  // register offsets on the 4-bit register port
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_RELOAD_LO = 4'h1;
  localparam logic [3:0] OFF_RELOAD_HI = 4'h2;
  localparam logic [3:0] OFF_COUNT_LO = 4'h3;
  localparam logic [3:0] OFF_COUNT_HI = 4'h4;
  localparam logic [3:0] OFF_CLKSEL = 4'h5;
  localparam logic [3:0] OFF_TMR_IE = 4'h6;
  localparam logic [3:0] OFF_EVT_STAT = 4'h7;
  localparam logic [3:0] OFF_EVT_CLR = 4'h8;
  localparam logic [3:0] OFF_EVT_EN = 4'h9;

  // timer_control_register field positions
  localparam int CTRL_HIGH_OVF = 7;
  localparam int CTRL_LOW_OVF = 6;
  localparam int CTRL_LOW_IE = 5;
  localparam int CTRL_CAPT_EN = 4;
  localparam int CTRL_SPLIT = 3;
  localparam int CTRL_RUN = 2;
  localparam int CTRL_XCLK_HI = 1;
  localparam int CTRL_XCLK_LO = 0;

  // clock_control_register fields and timer interrupt enable field
  localparam int CLKSEL_LOW = 0;
  localparam int CLKSEL_HIGH = 1;
  localparam int TMR_IE_BIT = 0;

  // event status layout: high overflow, low overflow, capture
  localparam int EVT_NUM = 3;
  localparam int EVT_HIGH_OVF = 0;
  localparam int EVT_LOW_OVF = 1;
  localparam int EVT_CAPTURE = 2;

  // external clock field encodings
  localparam logic [1:0] XCLK_SYS12_A = 2'h0;
  localparam logic [1:0] XCLK_EXT8 = 2'h1;
  localparam logic [1:0] XCLK_SYS12_B = 2'h2;
  localparam logic [1:0] XCLK_CMP = 2'h3;

  // reset values and the all-ones byte limit
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;

  // divider counts
  localparam int SYS_DIV = 12;
  localparam int EXT_DIV = 8;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);

endpackage

// file: hw/artmr_tick_if.sv
// interface: single-cycle count strobes from the clock source block to the timer core
`timescale 1ns/10ps
`default_nettype none
interface artmr_tick_if;
  logic sys12_tick; // one pulse every twelve system clocks
  logic ext8_tick; // one pulse every eight external oscillator cycles
  logic cmp_tick; // one pulse per comparator rising edge

  modport src (output sys12_tick, output ext8_tick, output cmp_tick);
  modport snk (input sys12_tick, input ext8_tick, input cmp_tick);
endinterface
`default_nettype wire

// file: hw/artmr_clk_src.sv
// clock source block: system divider, external/comparator synchronisers and strobes
`timescale 1ns/10ps
`default_nettype none
module artmr_clk_src (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic i_ext_osc, // external oscillator, asynchronous
  input wire logic i_comparator, // comparator output, asynchronous
  artmr_tick_if.src tick // count strobes
);
  logic [3:0] sys_div;
  logic [2:0] ext_div;
  logic ext_meta;
  logic ext_sync;
  logic ext_last;
  logic cmp_meta;
  logic cmp_sync;
  logic cmp_last;
  wire ext_rise = ext_sync & ~ext_last;
  wire cmp_rise = cmp_sync & ~cmp_last;
  wire sys_wrap = (sys_div == artmr_pkg::SYS_DIV_LAST);
  wire ext_wrap = ext_rise && (ext_div == artmr_pkg::EXT_DIV_LAST);

  // synchronise slow sources
  // first stages feed only the second stages, so no logic sees a metastable level
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_last <= 1'b0;
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
      cmp_last <= 1'b0;
    end else begin
      ext_meta <= i_ext_osc;
      ext_sync <= ext_meta;
      ext_last <= ext_sync;
      cmp_meta <= i_comparator;
      cmp_sync <= cmp_meta;
      cmp_last <= cmp_sync;
    end
  end

  // divide by twelve and eight
  // ext must stay below half the system rate or edges are lost
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sys_div <= 4'h0;
      ext_div <= 3'h0;
      tick.sys12_tick <= 1'b0;
      tick.ext8_tick <= 1'b0;
      tick.cmp_tick <= 1'b0;
    end else begin
      sys_div <= sys_wrap ? 4'h0 : sys_div + 4'h1;
      if (ext_rise) begin
        ext_div <= ext_div + 3'h1;
      end
      tick.sys12_tick <= sys_wrap;
      tick.ext8_tick <= ext_wrap;
      tick.cmp_tick <= cmp_rise;
    end
  end
endmodule
`default_nettype wire

// file: hw/artmr_evt_irq.sv
// event interrupt block: sticky status, write-one clear, enable and the interrupt line
`timescale 1ns/10ps
`default_nettype none
module artmr_evt_irq (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic [2:0] i_evt, // one-cycle event pulses
  input wire logic i_clr_we, // write to the clear register
  input wire logic i_en_we, // write to the enable register
  input wire logic [2:0] i_wdata, // write data
  input wire logic i_timer_irq, // level request from the overflow flags
  output logic [2:0] o_status, // sticky status
  output logic [2:0] o_enable, // enable register
  output logic o_irq // interrupt line
);
  wire any_evt = |(o_status & o_enable);

  // one sticky bit per event; a set in the clearing cycle is kept
  genvar g;
  generate
    for (g = 0; g < artmr_pkg::EVT_NUM; g = g + 1) begin : g_stat
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          o_status[g] <= 1'b0;
        end else if (i_evt[g]) begin
          o_status[g] <= 1'b1;
        end else if (i_clr_we && i_wdata[g]) begin
          o_status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // enable register and registered interrupt line
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_enable <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      if (i_en_we) begin
        o_enable <= i_wdata;
      end
      o_irq <= any_evt | i_timer_irq;
    end
  end
endmodule
`default_nettype wire

// file: hw/artmr_top.sv
// top of the auto-reload capture timer: register port, counter, reload and capture
// Functional notes
// - one 16-bit count from two bytes; split bit picks 16-bit or dual 8-bit
// - four clock sources; external and comparator synchronised to system clock
// - 16-bit mode at FFFF loads reload value (capture mode wraps to 0000), sets high flag
// - 16-bit mode with timer interrupt enabled interrupts on each full overflow
// - with low-byte enable too, low byte wrap also interrupts in 16-bit mode
// - split mode: each byte reloads from its own reload byte on its overflow
// - split mode: run bit gates only high byte; low byte always counts
// - per-byte select: 1 system clock, else external field picks the source
// - split mode: each byte wrap sets its own overflow flag
// - split mode interrupts on high wraps, and low wraps when low enable set
// - hardware never clears overflow flags; software clears them
// - capture trigger is comparator rise or eight external cycles, upper field bit
// - capture copies count into reload pair, sets high flag, may interrupt
// - capture times comparator or oscillator against system clock, sys/12 or the other source
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module artmr_top (
  input wire logic i_sys_clk, // 200 MHz system clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic [3:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic i_ext_osc, // external oscillator input
  input wire logic i_comparator, // comparator output
  output logic [7:0] o_rdata, // read data, valid the cycle after i_rd
  output logic o_irq // level interrupt
);
  // count strobes
  artmr_tick_if tick ();

  // software-visible state
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;

  // control fields
  logic high_overflow_flag;
  logic low_overflow_flag;
  logic low_byte_irq_enable;
  logic capture_enable;
  logic split_mode_select;
  logic run_control;
  logic [1:0] external_clock_field;

  // selects and enable
  logic high_byte_clock_select;
  logic low_byte_clock_select;
  logic timer_irq_enable;

  // event block
  logic [2:0] evt_status;
  logic [2:0] evt_enable;
  logic irq_line;

  // address decode
  // unmapped offsets decode to nothing
  wire wr_ctrl = i_wr && (i_addr == artmr_pkg::OFF_CTRL);
  wire wr_rl_lo = i_wr && (i_addr == artmr_pkg::OFF_RELOAD_LO);
  wire wr_rl_hi = i_wr && (i_addr == artmr_pkg::OFF_RELOAD_HI);
  wire wr_cnt_lo = i_wr && (i_addr == artmr_pkg::OFF_COUNT_LO);
  wire wr_cnt_hi = i_wr && (i_addr == artmr_pkg::OFF_COUNT_HI);
  wire wr_clksel = i_wr && (i_addr == artmr_pkg::OFF_CLKSEL);
  wire wr_tmr_ie = i_wr && (i_addr == artmr_pkg::OFF_TMR_IE);
  wire wr_evt_clr = i_wr && (i_addr == artmr_pkg::OFF_EVT_CLR);
  wire wr_evt_en = i_wr && (i_addr == artmr_pkg::OFF_EVT_EN);

  artmr_clk_src u_clk_src (
    .i_sys_clk (i_sys_clk),
    .i_rst_b (i_rst_b),
    .i_ext_osc (i_ext_osc),
    .i_comparator (i_comparator),
    .tick (tick.src)
  );

  // shared external source per field
  // codes 00 and 10 both give the divide-by-twelve strobe
  wire ext_src_tick = (external_clock_field == artmr_pkg::XCLK_EXT8) ? tick.ext8_tick :
                      (external_clock_field == artmr_pkg::XCLK_CMP) ? tick.cmp_tick :
                      tick.sys12_tick;

  // per-byte clock select
  // select 1 steps every cycle
  wire low_src_tick = low_byte_clock_select ? 1'b1 : ext_src_tick;
  wire high_src_tick = high_byte_clock_select ? 1'b1 : ext_src_tick;

  // capture trigger from upper field bit
  // bit 0 times comparator edges, 1 oscillator/8 cycles
  // code 01 times the comparator on the oscillator, 11 the reverse
  wire capture_trigger_select = external_clock_field[1];
  wire capt_trig = capture_trigger_select ? tick.ext8_tick : tick.cmp_tick;
  wire capt_evt = capture_enable && capt_trig;

  // run bit gates high byte only in split mode
  // 16-bit mode steps on the low byte select
  wire step16 = !split_mode_select && run_control && low_src_tick;
  wire step_lo8 = split_mode_select && low_src_tick;
  wire step_hi8 = split_mode_select && run_control && high_src_tick;

  // byte limits
  wire lo_at_max = (count_low_byte == artmr_pkg::BYTE_ALL_ONES);
  wire hi_at_max = (count_high_byte == artmr_pkg::BYTE_ALL_ONES);
  wire [15:0] count16 = {count_high_byte, count_low_byte};
  wire [15:0] inc16 = count16 + 16'h0001;

  wire wrap16 = step16 && lo_at_max && hi_at_max;
  // per-byte wraps; the low byte also wraps inside the 16-bit count
  wire wrap_lo = (step16 || step_lo8) && lo_at_max;
  // high wraps on a full or own wrap
  wire wrap_hi = wrap16 || (step_hi8 && hi_at_max);

  // capture sets the high flag as an overflow does
  wire set_hi_flag = wrap_hi || capt_evt;
  wire set_lo_flag = wrap_lo;

  // next count: software write wins over counting in the same cycle
  logic [7:0] next_count_lo;
  logic [7:0] next_count_hi;
  always_comb begin
    next_count_lo = count_low_byte;
    next_count_hi = count_high_byte;

    if (step16) begin
      if (wrap16 && !capture_enable) begin
        // reload lands with the flag set
        next_count_lo = reload_low_byte;
        next_count_hi = reload_high_byte;
      end else begin
        // capture mode wraps freely so capture differences stay valid
        next_count_lo = inc16[7:0];
        next_count_hi = inc16[15:8];
      end
    end

    if (step_lo8) begin
      // low byte reloads from low reload
      next_count_lo = lo_at_max ? reload_low_byte : count_low_byte + 8'h01;
    end

    if (step_hi8) begin
      // high byte reloads from high reload
      next_count_hi = hi_at_max ? reload_high_byte : count_high_byte + 8'h01;
    end

    if (wr_cnt_lo) begin
      next_count_lo = i_wdata;
    end

    if (wr_cnt_hi) begin
      next_count_hi = i_wdata;
    end
  end

  // counter bytes
  // strobes gate the next value
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_low_byte <= artmr_pkg::RST_BYTE;
      count_high_byte <= artmr_pkg::RST_BYTE;
    end else begin
      count_low_byte <= next_count_lo;
      count_high_byte <= next_count_hi;
    end
  end

  // capture copies the count into the reload pair
  // copy lands in the flag-set cycle
  // a capture beats a software write to the reload pair in the same cycle
  wire [7:0] next_reload_lo = capt_evt ? count_low_byte :
                              wr_rl_lo ? i_wdata : reload_low_byte;
  wire [7:0] next_reload_hi = capt_evt ? count_high_byte :
                              wr_rl_hi ? i_wdata : reload_high_byte;

  // reload pair
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      reload_low_byte <= artmr_pkg::RST_BYTE;
      reload_high_byte <= artmr_pkg::RST_BYTE;
    end else begin
      reload_low_byte <= next_reload_lo;
      reload_high_byte <= next_reload_hi;
    end
  end

  // flags set by hardware events or a software write of one, cleared only by software
  // a set in the same cycle as a software clear wins
  wire next_hi_flag = set_hi_flag ||
                      (wr_ctrl ? i_wdata[artmr_pkg::CTRL_HIGH_OVF] : high_overflow_flag);
  wire next_lo_flag = set_lo_flag ||
                      (wr_ctrl ? i_wdata[artmr_pkg::CTRL_LOW_OVF] : low_overflow_flag);

  // timer_control_register
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      high_overflow_flag <= 1'b0;
      low_overflow_flag <= 1'b0;
      low_byte_irq_enable <= 1'b0;
      capture_enable <= 1'b0;
      split_mode_select <= 1'b0;
      run_control <= 1'b0;
      external_clock_field <= 2'h0;
    end else begin
      high_overflow_flag <= next_hi_flag;
      low_overflow_flag <= next_lo_flag;

      if (wr_ctrl) begin
        low_byte_irq_enable <= i_wdata[artmr_pkg::CTRL_LOW_IE];
        capture_enable <= i_wdata[artmr_pkg::CTRL_CAPT_EN];
        split_mode_select <= i_wdata[artmr_pkg::CTRL_SPLIT];
        run_control <= i_wdata[artmr_pkg::CTRL_RUN];
        external_clock_field <= i_wdata[artmr_pkg::CTRL_XCLK_HI:artmr_pkg::CTRL_XCLK_LO];
      end
    end
  end

  // clock select and timer interrupt enable
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      high_byte_clock_select <= 1'b0;
      low_byte_clock_select <= 1'b0;
      timer_irq_enable <= 1'b0;
    end else begin
      if (wr_clksel) begin
        high_byte_clock_select <= i_wdata[artmr_pkg::CLKSEL_HIGH];
        low_byte_clock_select <= i_wdata[artmr_pkg::CLKSEL_LOW];
      end

      if (wr_tmr_ie) begin
        timer_irq_enable <= i_wdata[artmr_pkg::TMR_IE_BIT];
      end
    end
  end

  // clearing flags drops it
  // high flag requests in every mode
  // low flag adds in every mode when low enable set
  // capture shares the high flag path
  wire timer_irq = timer_irq_enable &&
                   (high_overflow_flag || (low_byte_irq_enable && low_overflow_flag));

  // event status, clear and enable
  // pulses last one cycle
  wire [2:0] evt_pulse;
  assign evt_pulse[artmr_pkg::EVT_HIGH_OVF] = wrap_hi;
  assign evt_pulse[artmr_pkg::EVT_LOW_OVF] = wrap_lo;
  assign evt_pulse[artmr_pkg::EVT_CAPTURE] = capt_evt;

  // event wins over a clear
  artmr_evt_irq u_evt_irq (
    .i_sys_clk (i_sys_clk),
    .i_rst_b (i_rst_b),
    .i_evt (evt_pulse),
    .i_clr_we (wr_evt_clr),
    .i_en_we (wr_evt_en),
    .i_wdata (i_wdata[2:0]),
    .i_timer_irq (timer_irq),
    .o_status (evt_status),
    .o_enable (evt_enable),
    .o_irq (irq_line)
  );

  // read mux; write-only and unmapped offsets read zero
  // count bytes are not latched
  wire [7:0] ctrl_rd = {high_overflow_flag, low_overflow_flag, low_byte_irq_enable,
                        capture_enable, split_mode_select, run_control, external_clock_field};
  wire [7:0] rd_mux = (i_addr == artmr_pkg::OFF_CTRL) ? ctrl_rd :
                      (i_addr == artmr_pkg::OFF_RELOAD_LO) ? reload_low_byte :
                      (i_addr == artmr_pkg::OFF_RELOAD_HI) ? reload_high_byte :
                      (i_addr == artmr_pkg::OFF_COUNT_LO) ? count_low_byte :
                      (i_addr == artmr_pkg::OFF_COUNT_HI) ? count_high_byte :
                      (i_addr == artmr_pkg::OFF_CLKSEL) ?
                        {6'h00, high_byte_clock_select, low_byte_clock_select} :
                      (i_addr == artmr_pkg::OFF_TMR_IE) ? {7'h00, timer_irq_enable} :
                      (i_addr == artmr_pkg::OFF_EVT_STAT) ? {5'h00, evt_status} :
                      (i_addr == artmr_pkg::OFF_EVT_EN) ? {5'h00, evt_enable} :
                      8'h00;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_mux : 8'h00;
    end
  end

  // irq is already a flop inside the event block; pass it straight out
  assign o_irq = irq_line;
endmodule
`default_nettype wire

// file: tb/artmr_top_asserts.sv
// checker: port-level properties of the auto-reload capture timer
`timescale 1ns/10ps
`default_nettype none
module artmr_top_asserts (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic [3:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic i_ext_osc, // external oscillator
  input wire logic i_comparator, // comparator output
  input wire logic [7:0] o_rdata, // read data
  input wire logic o_irq // interrupt
);
  logic ie_sh, cap_ever, rd_q, hi_seen, lo_seen;
  logic [2:0] en_sh;
  logic [7:0] rl_lo_sh;
  logic [3:0] addr_q;
  wire wr_ctrl = i_wr && (i_addr == artmr_pkg::OFF_CTRL);
  wire rd_ctrl = rd_q && (addr_q == artmr_pkg::OFF_CTRL);
  wire rd_lo = rd_q && (addr_q == artmr_pkg::OFF_RELOAD_LO);
  wire rd_ie = rd_q && (addr_q == artmr_pkg::OFF_TMR_IE);
  wire rd_en = rd_q && (addr_q == artmr_pkg::OFF_EVT_EN);
  // shadows of what software wrote; flags seen high stay remembered until a control write
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {ie_sh, cap_ever, rd_q, hi_seen, lo_seen} <= 5'h00;
      en_sh <= 3'h0;
      rl_lo_sh <= 8'h00;
      addr_q <= 4'h0;
    end else begin
      rd_q <= i_rd;
      addr_q <= i_addr;
      if (i_wr && i_addr == artmr_pkg::OFF_TMR_IE) ie_sh <= i_wdata[0];
      if (i_wr && i_addr == artmr_pkg::OFF_EVT_EN) en_sh <= i_wdata[2:0];
      if (i_wr && i_addr == artmr_pkg::OFF_RELOAD_LO) rl_lo_sh <= i_wdata;
      if (wr_ctrl && i_wdata[4]) cap_ever <= 1'b1;
      hi_seen <= wr_ctrl ? 1'b0 : (hi_seen | (rd_ctrl & o_rdata[7]));
      lo_seen <= wr_ctrl ? 1'b0 : (lo_seen | (rd_ctrl & o_rdata[6]));
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  property p_rdata_idle;
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_high_kept;
    rd_ctrl && hi_seen |-> o_rdata[7];
  endproperty
  a_high_kept: assert property (p_high_kept) else $error("high flag lost");
  property p_low_kept;
    rd_ctrl && lo_seen |-> o_rdata[6];
  endproperty
  a_low_kept: assert property (p_low_kept) else $error("low flag lost");
  property p_irq_high;
    rd_ctrl && o_rdata[7] && ie_sh |-> o_irq;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("no irq on high flag");
  property p_irq_low;
    rd_ctrl && o_rdata[6] && o_rdata[5] && ie_sh |-> o_irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("no irq on low flag");
  property p_irq_cause;
    $rose(o_irq) |-> ie_sh || (en_sh != 3'h0);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enable");
  property p_reload_kept;
    rd_lo && !cap_ever |-> o_rdata == rl_lo_sh;
  endproperty
  a_reload_kept: assert property (p_reload_kept) else $error("reload changed");
  property p_ie_read;
    rd_ie |-> o_rdata == {7'h00, ie_sh};
  endproperty
  a_ie_read: assert property (p_ie_read) else $error("enable readback");
  property p_en_read;
    rd_en |-> o_rdata == {5'h00, en_sh};
  endproperty
  a_en_read: assert property (p_en_read) else $error("event enable readback");
endmodule
bind artmr_top artmr_top_asserts u_chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_osc(i_ext_osc),
  .i_comparator(i_comparator), .o_rdata(o_rdata), .o_irq(o_irq));
`default_nettype wire

// file: tb/artmr_far_side.sv
// far-side model: external oscillator and comparator feeding the timer
`timescale 1ns/10ps
`default_nettype none
module artmr_far_side (
  input wire logic i_osc_en, // run the oscillator
  output logic o_ext_osc, // oscillator, 25 MHz, eight system clocks a period
  output logic o_comparator // comparator, idles low
);
  localparam int OSC_HALF_NS = 20;
  initial begin
    o_ext_osc = 1'b0;
    o_comparator = 1'b0;
  end
  // stands low while disabled so no stray ext/8 strobes arrive
  always begin
    #(OSC_HALF_NS);
    o_ext_osc = i_osc_en ? !o_ext_osc : 1'b0;
  end
  // slow enough for the two-flop synchroniser to see every edge
  task automatic pulse_cmp(input int n);
    #1;
    repeat (n) begin
      #20;
      o_comparator = 1'b1;
      #20;
      o_comparator = 1'b0;
      #40;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/artmr_top_tb.sv
// testbench: register-level scenarios for the auto-reload capture timer
`timescale 1ns/10ps
`default_nettype none
module artmr_top_tb;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic osc_en = 1'b0;
  logic ext_osc, cmp, o_irq;
  logic [7:0] o_rdata;
  int num_errors = 0;
  int num_checks = 0;
  always #2.5 i_sys_clk = !i_sys_clk;
  artmr_top uut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_osc(ext_osc),
    .i_comparator(cmp), .o_rdata(o_rdata), .o_irq(o_irq));
  artmr_far_side far (.i_osc_en(osc_en), .o_ext_osc(ext_osc), .o_comparator(cmp));
  task automatic final_report();
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // each access waits an edge first so strobes never change twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic wait_flag(input int b);
    logic [7:0] v;
    for (int i = 0; i < 500; i++) begin
      rd(artmr_pkg::OFF_CTRL, v);
      if (v[b] === 1'b1) return;
    end
    num_errors++;
    final_report();
  endtask
  task automatic t_reset();
    logic [7:0] v;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), v);
      chk("reset value", {8'h00, v}, 16'h0000);
    end
  endtask
  task automatic t_wide();
    logic [7:0] v;
    wr(artmr_pkg::OFF_RELOAD_LO, 8'h34);
    wr(artmr_pkg::OFF_RELOAD_HI, 8'h12);
    wr(artmr_pkg::OFF_COUNT_LO, 8'hFE);
    wr(artmr_pkg::OFF_COUNT_HI, 8'hFF);
    wr(artmr_pkg::OFF_CLKSEL, 8'h01);
    wr(artmr_pkg::OFF_TMR_IE, 8'h01);
    wr(artmr_pkg::OFF_CTRL, 8'h04);
    wait_flag(7);
    rd(artmr_pkg::OFF_COUNT_HI, v);
    chk("reloaded high", {8'h00, v}, 16'h0012);
    chk("irq wide", {15'h0, o_irq}, 16'h0001);
    rd(artmr_pkg::OFF_RELOAD_LO, v);
    chk("reload kept", {8'h00, v}, 16'h0034);
    cyc(20);
    rd(artmr_pkg::OFF_CTRL, v);
    chk("flags kept", {8'h00, v}, 16'h00C4);
    wr(artmr_pkg::OFF_CTRL, 8'hC0);
    rd(artmr_pkg::OFF_EVT_STAT, v);
    chk("event status", {8'h00, v}, 16'h0003);
    wr(artmr_pkg::OFF_TMR_IE, 8'h00);
    wr(artmr_pkg::OFF_CTRL, 8'h00);
    cyc(2);
    chk("irq masked", {15'h0, o_irq}, 16'h0000);
    wr(artmr_pkg::OFF_EVT_EN, 8'h01);
    cyc(2);
    chk("event irq", {15'h0, o_irq}, 16'h0001);
    wr(artmr_pkg::OFF_EVT_CLR, 8'h07);
    cyc(2);
    chk("event cleared", {15'h0, o_irq}, 16'h0000);
    rd(artmr_pkg::OFF_EVT_STAT, v);
    chk("status cleared", {8'h00, v}, 16'h0000);
    wr(artmr_pkg::OFF_EVT_EN, 8'h00);
  endtask
  task automatic t_low_ie(input logic [7:0] ctrl, input logic exp_irq);
    logic [7:0] v;
    wr(artmr_pkg::OFF_TMR_IE, 8'h01);
    wr(artmr_pkg::OFF_COUNT_LO, 8'hF0);
    wr(artmr_pkg::OFF_CTRL, ctrl);
    wait_flag(6);
    cyc(2);
    chk("low wrap irq", {15'h0, o_irq}, {15'h0, exp_irq});
    rd(artmr_pkg::OFF_CTRL, v);
    chk("only low flag", {8'h00, v & 8'hC0}, 16'h0040);
    wr(artmr_pkg::OFF_CTRL, 8'h00);
  endtask
  task automatic t_split();
    logic [7:0] v;
    wr(artmr_pkg::OFF_CLKSEL, 8'h03);
    wr(artmr_pkg::OFF_RELOAD_LO, 8'h80);
    wr(artmr_pkg::OFF_RELOAD_HI, 8'h40);
    wr(artmr_pkg::OFF_COUNT_HI, 8'h05);
    wr(artmr_pkg::OFF_COUNT_LO, 8'hF0);
    wr(artmr_pkg::OFF_CTRL, 8'h08);
    wait_flag(6);
    cyc(2);
    chk("split irq off", {15'h0, o_irq}, 16'h0000);
    rd(artmr_pkg::OFF_COUNT_HI, v);
    chk("high held", {8'h00, v}, 16'h0005);
    rd(artmr_pkg::OFF_COUNT_LO, v);
    chk("low reload", {15'h0, v[7]}, 16'h0001);
    // software reads both flags to tell the bytes apart
    rd(artmr_pkg::OFF_CTRL, v);
    chk("split flags", {8'h00, v & 8'hC0}, 16'h0040);
    wr(artmr_pkg::OFF_CTRL, 8'h68);
    cyc(2);
    chk("split low irq", {15'h0, o_irq}, 16'h0001);
    wr(artmr_pkg::OFF_COUNT_HI, 8'hF0);
    wr(artmr_pkg::OFF_CTRL, 8'h0C);
    wait_flag(7);
    rd(artmr_pkg::OFF_COUNT_HI, v);
    chk("high reload", {14'h0, v[7:6]}, 16'h0001);
    chk("split high irq", {15'h0, o_irq}, 16'h0001);
    wr(artmr_pkg::OFF_CTRL, 8'h00);
    wr(artmr_pkg::OFF_TMR_IE, 8'h00);
  endtask
  task automatic t_src(input logic [1:0] f, input logic s, input int n, input int p,
                       input int lo, input int hi);
    logic [7:0] v;
    wr(artmr_pkg::OFF_CLKSEL, {7'h00, s});
    wr(artmr_pkg::OFF_COUNT_LO, 8'h00);
    wr(artmr_pkg::OFF_COUNT_HI, 8'h00);
    wr(artmr_pkg::OFF_CTRL, {6'h01, f});
    if (p > 0) far.pulse_cmp(p);
    cyc(n);
    wr(artmr_pkg::OFF_CTRL, {6'h00, f});
    rd(artmr_pkg::OFF_COUNT_LO, v);
    chk("source count", {15'h0, (v >= lo) && (v <= hi)}, 16'h0001);
  endtask
  task automatic t_capture();
    logic [7:0] a, b, c, d;
    wr(artmr_pkg::OFF_CLKSEL, 8'h01);
    wr(artmr_pkg::OFF_TMR_IE, 8'h01);
    // split stays cleared while the full counter captures
    wr(artmr_pkg::OFF_CTRL, 8'h16);
    wait_flag(7);
    wr(artmr_pkg::OFF_CTRL, 8'h16);
    rd(artmr_pkg::OFF_RELOAD_LO, a);
    rd(artmr_pkg::OFF_RELOAD_HI, b);
    wait_flag(7);
    chk("capture irq", {15'h0, o_irq}, 16'h0001);
    rd(artmr_pkg::OFF_RELOAD_LO, c);
    rd(artmr_pkg::OFF_RELOAD_HI, d);
    // the period is the difference of two captures
    chk("capture period", {d, c} - {b, a}, 16'h0040);
    wr(artmr_pkg::OFF_CTRL, 8'h14);
    cyc(100);
    rd(artmr_pkg::OFF_CTRL, a);
    chk("no ext capture", {8'h00, a & 8'h80}, 16'h0000);
    far.pulse_cmp(1);
    cyc(10);
    rd(artmr_pkg::OFF_CTRL, a);
    chk("cmp capture", {8'h00, a & 8'h80}, 16'h0080);
    wr(artmr_pkg::OFF_CTRL, 8'h00);
  endtask
  initial begin
    cyc(10);
    i_rst_b <= 1'b1;
    osc_en <= 1'b1;
    t_reset();
    t_wide();
    t_low_ie(8'h24, 1'b1);
    t_low_ie(8'h04, 1'b0);
    t_split();
    // both sys/12 codes, ext/8, comparator and the direct system clock
    t_src(2'h0, 1'b0, 240, 0, 18, 23);
    t_src(2'h2, 1'b0, 240, 0, 18, 23);
    t_src(2'h1, 1'b0, 640, 0, 9, 11);
    t_src(2'h3, 1'b0, 10, 5, 5, 5);
    t_src(2'h1, 1'b1, 50, 0, 50, 56);
    t_capture();
    final_report();
  end
endmodule
`default_nettype wire
